// [rtl/pmr_pkg.sv]
// shared constants and carriers of the management register bank
// assumes a 250 MHz register clock and word-aligned ahb-lite accesses
package pmr_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_IDENT_HIGH = 6'h02;
    localparam logic [IDX_W-1:0] IDX_IDENT_LOW = 6'h03;
    localparam logic [IDX_W-1:0] IDX_EXT_CTRL = 6'h0d;
    localparam logic [IDX_W-1:0] IDX_EXT_WINDOW = 6'h0e;
    localparam logic [IDX_W-1:0] IDX_LINK_STATUS = 6'h10;
    localparam logic [IDX_W-1:0] IDX_MISC_CFG = 6'h11;
    localparam logic [IDX_W-1:0] IDX_EVENT_A = 6'h12;
    localparam logic [IDX_W-1:0] IDX_EVENT_B = 6'h13;
    localparam logic [IDX_W-1:0] IDX_CORE_RESET = 6'h1f;

    // ------------------------------------------------------------------
    // field layouts and reset values
    // ------------------------------------------------------------------
    localparam int DW = 16;
    localparam int CMD_LO = 14;
    localparam int DEV_W = 5;
    localparam logic [DW-1:0] EXT_CTRL_MASK = 16'hc01f;
    localparam int ST_SIG_DET = 10;
    localparam int ST_DESCR = 9;
    localparam int ST_INT_SEEN = 7;
    localparam int ST_LOOPBACK = 3;
    localparam int ST_DUPLEX = 2;
    localparam int ST_LINK = 0;
    localparam int CF_DIS_CLK = 15;
    localparam int CF_PSAVE = 14;
    localparam int CF_SGMII_RST = 11;
    localparam int CF_ISOLATE = 10;
    localparam int CF_CH_DEBUG = 9;
    localparam int CF_DEBUG = 8;
    localparam int CF_NON_CLEAR = 6;
    localparam int CF_RTIME_LO = 4;
    localparam int CF_POL = 3;
    localparam int CF_FORCE = 2;
    localparam int CF_INT_EN = 1;
    localparam logic [DW-1:0] CFG_RW_MASK = 16'hc77e;
    localparam logic [DW-1:0] CFG_RESET = 16'h000a;
    localparam int CR_DIG_RST = 14;
    localparam int EV_STAT_LO = 8;
    localparam logic [7:0] EV_A_MASK = 8'hec;
    localparam logic [7:0] EV_B_MASK = 8'hcf;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int T_RST0_NS = 120;
    localparam int T_RST1_US = 32;
    localparam int T_RST2_US = 256;
    localparam int T_RST3_US = 1024;
    localparam int RST_CYC0 = (T_RST0_NS * CLK_MHZ + 999) / 1000;
    localparam int RST_CYC1_DEF = T_RST1_US * CLK_MHZ;
    localparam int RST_CYC2_DEF = T_RST2_US * CLK_MHZ;
    localparam int RST_CYC3_DEF = T_RST3_US * CLK_MHZ;
    localparam int RST_CNT_W = 18;

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CMD_ADDR = 2'h0,
        CMD_DATA = 2'h1,
        CMD_INC_RW = 2'h2,
        CMD_INC_W = 2'h3
    } pmr_cmd_t;

    typedef enum logic {PH_IDLE, PH_DATA} pmr_phase_t;

    typedef struct packed {
        logic channel_ok;
        logic descr_lock;
        logic link_up;
        logic full_duplex;
        logic loopback;
        logic power_save;
    } pmr_link_t;

    typedef struct packed {
        logic link_qual;
        logic energy_chg;
        logic link_chg;
        logic esd;
        logic training_complete_event;
        logic under_volt;
        logic over_volt;
        logic over_temp;
        logic sleep_chg;
        logic pol_chg;
        logic not_one_hot;
    } pmr_events_t;

endpackage

// [rtl/pmr_regs.sv]
// management register bank: identity, extended access window, latched
// link status, interrupt/reset configuration and two event banks
// assumes one ahb-lite master; link and event inputs synchronous to hclk
`timescale 1ns/1ps

module pmr_regs #(
    parameter logic [15:0] ID_HIGH = 16'h1a2b, // arbitrary value
    parameter logic [15:0] ID_LOW = 16'h3c4d, // arbitrary value
    parameter int EXT_AW = 4,
    parameter int RST_CYC1 = pmr_pkg::RST_CYC1_DEF,
    parameter int RST_CYC2 = pmr_pkg::RST_CYC2_DEF,
    parameter int RST_CYC3 = pmr_pkg::RST_CYC3_DEF
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire pmr_pkg::pmr_link_t link_i,
    input wire pmr_pkg::pmr_events_t events_i,
    input wire logic [4:0] strap_addr,
    output logic int_pin,
    output logic mac_clk_stop,
    output logic isolate,
    output logic power_save_en,
    output logic debug_en,
    output logic chan_debug_en,
    output logic sgmii_reset,
    output logic core_reset
);
    import pmr_pkg::*;

    localparam int EXT_IW = DEV_W + EXT_AW;

    if (EXT_AW < 1 || EXT_AW > DW) begin : g_chk_aw
        $error("EXT_AW out of range");
    end
    if (RST_CYC1 < 1 || RST_CYC2 < 1 || RST_CYC3 < 1 ||
        RST_CYC1 >= 2**RST_CNT_W || RST_CYC2 >= 2**RST_CNT_W ||
        RST_CYC3 >= 2**RST_CNT_W) begin : g_chk_rst
        $error("reset cycle count does not fit the counter");
    end

    function automatic logic [EXT_IW-1:0] ext_index(
        input logic [DEV_W-1:0] dev, input logic [DW-1:0] a);
        ext_index = {dev, a[EXT_AW-1:0]};
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    pmr_phase_t phase_ff, nxt_phase;
    logic [IDX_W-1:0] idx_ff, nxt_idx;
    logic wr_ff, nxt_wr, mapped_ff, nxt_mapped;
    logic hreadyout_ff, nxt_hreadyout;
    logic [DW-1:0] hrdata_ff, nxt_hrdata;
    logic [DW-1:0] ext_ctrl_ff, nxt_ext_ctrl;
    logic [DW-1:0] ext_addr_ff, nxt_ext_addr;
    logic lost_chan_ff, nxt_lost_chan, lost_descr_ff, nxt_lost_descr;
    logic lost_link_ff, nxt_lost_link, int_seen_ff, nxt_int_seen;
    logic duplex_ff, nxt_duplex;
    logic [DW-1:0] cfg_ff, nxt_cfg;
    logic sgmii_rst_ff, nxt_sgmii_rst, dig_rst_ff, nxt_dig_rst;
    logic [RST_CNT_W-1:0] rst_cnt_ff, nxt_rst_cnt;
    logic [4:0] strap_ff, nxt_strap;
    logic strap_done_ff, nxt_strap_done;
    logic int_act_ff, nxt_int_act, int_pin_ff, nxt_int_pin;
    logic clk_stop_ff, nxt_clk_stop, isolate_ff, nxt_isolate;
    logic [7:0] ev_st_ff [2];
    logic [7:0] ev_en_ff [2];
    logic [DW-1:0] ext_mem [2**EXT_IW];

    logic acc, rd_acc, wr_acc, mem_we;
    logic [DW-1:0] wdat;
    logic [EXT_IW-1:0] ext_idx;
    pmr_cmd_t cmd;
    logic [7:0] ev_in [2];
    logic [7:0] ev_mask [2];
    logic [1:0] ev_rd;
    logic [1:0] ev_wr;

    assign acc = (phase_ff == PH_DATA) && mapped_ff;
    assign rd_acc = acc && !wr_ff;
    assign wr_acc = acc && wr_ff;
    assign wdat = hwdata[DW-1:0];
    assign cmd = pmr_cmd_t'(ext_ctrl_ff[CMD_LO +: 2]);
    assign ext_idx = ext_index(ext_ctrl_ff[DEV_W-1:0], ext_addr_ff);
    assign mem_we = wr_acc && idx_ff == IDX_EXT_WINDOW && cmd != CMD_ADDR;

    assign ev_in[0] = {events_i.link_qual, events_i.energy_chg,
        events_i.link_chg, 1'b0, events_i.esd,
        events_i.training_complete_event, 2'b00};
    assign ev_in[1] = {events_i.under_volt, events_i.over_volt, 2'b00,
        events_i.over_temp, events_i.sleep_chg, events_i.pol_chg,
        events_i.not_one_hot};
    assign ev_mask[0] = EV_A_MASK;
    assign ev_mask[1] = EV_B_MASK;
    assign ev_rd[0] = rd_acc && idx_ff == IDX_EVENT_A;
    assign ev_rd[1] = rd_acc && idx_ff == IDX_EVENT_B;
    assign ev_wr[0] = wr_acc && idx_ff == IDX_EVENT_A;
    assign ev_wr[1] = wr_acc && idx_ff == IDX_EVENT_B;

    // ------------------------------------------------------------------
    // event banks
    // ------------------------------------------------------------------
    for (genvar b = 0; b < 2; b++) begin : g_bank
        logic [7:0] nxt_st, nxt_en;
        always_comb begin
            nxt_en = ev_wr[b] ? wdat[7:0] : ev_en_ff[b];
            // clear on read, a new event in the same cycle wins
            nxt_st = (ev_st_ff[b] & ~{8{ev_rd[b]}}) |
                (ev_in[b] & ev_mask[b]);
        end
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                ev_st_ff[b] <= 8'h00;
                ev_en_ff[b] <= 8'h00;
            end else begin
                ev_st_ff[b] <= nxt_st;
                ev_en_ff[b] <= nxt_en;
            end
        end
    end

    // ------------------------------------------------------------------
    // extended register storage
    // ------------------------------------------------------------------
    always_ff @(posedge hclk) begin
        if (mem_we) begin
            ext_mem[ext_idx] <= wdat;
        end
    end

    // ------------------------------------------------------------------
    // bus, registers, reset timer, interrupt
    // ------------------------------------------------------------------
    always_comb begin
        logic [DW-1:0] st;
        logic [DW-1:0] rv;
        logic trig;
        logic [RST_CNT_W-1:0] load;
        st = '0;
        rv = '0;
        trig = 1'b0;
        load = '0;
        nxt_phase = phase_ff;
        nxt_idx = idx_ff;
        nxt_wr = wr_ff;
        nxt_mapped = mapped_ff;
        nxt_hreadyout = hreadyout_ff;
        nxt_hrdata = hrdata_ff;
        nxt_ext_ctrl = ext_ctrl_ff;
        nxt_ext_addr = ext_addr_ff;
        nxt_cfg = cfg_ff;
        nxt_sgmii_rst = sgmii_rst_ff;
        nxt_dig_rst = dig_rst_ff;
        nxt_rst_cnt = rst_cnt_ff;
        nxt_strap = strap_ff;
        nxt_strap_done = 1'b1;
        if (!strap_done_ff) begin
            nxt_strap = strap_addr;
        end
        // status view with latched drops
        st[ST_SIG_DET] = link_i.channel_ok && !lost_chan_ff;
        st[ST_DESCR] = link_i.descr_lock && !lost_descr_ff;
        st[ST_INT_SEEN] = int_seen_ff;
        st[ST_LOOPBACK] = link_i.loopback;
        st[ST_DUPLEX] = duplex_ff;
        st[ST_LINK] = link_i.link_up && !lost_link_ff;
        nxt_duplex = link_i.full_duplex;
        unique case (phase_ff)
            PH_IDLE: begin
                if (hsel && htrans[1] && hready) begin
                    nxt_phase = PH_DATA;
                    nxt_idx = haddr[IDX_W+1:2];
                    nxt_wr = hwrite;
                    nxt_mapped = (haddr[31:IDX_W+2] == '0);
                    nxt_hreadyout = 1'b0;
                end
            end
            PH_DATA: begin
                nxt_phase = PH_IDLE;
                nxt_hreadyout = 1'b1;
            end
        endcase
        // read data
        unique case (idx_ff)
            IDX_IDENT_HIGH: rv = ID_HIGH;
            IDX_IDENT_LOW: rv = ID_LOW;
            IDX_EXT_CTRL: rv = ext_ctrl_ff;
            IDX_EXT_WINDOW: rv = (cmd == CMD_ADDR) ? ext_addr_ff
                : ext_mem[ext_idx];
            IDX_LINK_STATUS: rv = st;
            IDX_MISC_CFG: rv = cfg_ff | (DW'(sgmii_rst_ff) << CF_SGMII_RST);
            IDX_EVENT_A: rv = {ev_st_ff[0], ev_en_ff[0]};
            IDX_EVENT_B: rv = {ev_st_ff[1], ev_en_ff[1]};
            IDX_CORE_RESET: rv = DW'(dig_rst_ff) << CR_DIG_RST;
            default: rv = '0;
        endcase
        if (rd_acc) begin
            nxt_hrdata = rv;
        end else if (phase_ff == PH_DATA) begin
            nxt_hrdata = '0;
        end
        // extended access control and window
        if (wr_acc && idx_ff == IDX_EXT_CTRL) begin
            nxt_ext_ctrl = wdat & EXT_CTRL_MASK;
        end
        if (wr_acc && idx_ff == IDX_EXT_WINDOW) begin
            if (cmd == CMD_ADDR) begin
                nxt_ext_addr = wdat;
            end else if (cmd != CMD_DATA) begin
                nxt_ext_addr = ext_addr_ff + 16'h0001;
            end
        end
        if (rd_acc && idx_ff == IDX_EXT_WINDOW && cmd == CMD_INC_RW) begin
            nxt_ext_addr = ext_addr_ff + 16'h0001;
        end
        // configuration and reset timing
        if (wr_acc && idx_ff == IDX_MISC_CFG) begin
            nxt_cfg = wdat & CFG_RW_MASK;
        end
        if (wr_acc && idx_ff == IDX_MISC_CFG && wdat[CF_SGMII_RST]) begin
            nxt_sgmii_rst = 1'b1;
            trig = 1'b1;
        end
        if (wr_acc && idx_ff == IDX_CORE_RESET) begin
            nxt_dig_rst = wdat[CR_DIG_RST];
            trig = wdat[CR_DIG_RST];
        end
        unique case (cfg_ff[CF_RTIME_LO +: 2])
            2'h0: load = RST_CNT_W'(RST_CYC0);
            2'h1: load = RST_CNT_W'(RST_CYC1);
            2'h2: load = RST_CNT_W'(RST_CYC2);
            2'h3: load = RST_CNT_W'(RST_CYC3);
        endcase
        if (trig) begin
            nxt_rst_cnt = load;
        end else if (rst_cnt_ff != '0) begin
            nxt_rst_cnt = rst_cnt_ff - RST_CNT_W'(1);
            if (rst_cnt_ff == RST_CNT_W'(1)) begin
                nxt_sgmii_rst = 1'b0;
                if (!cfg_ff[CF_NON_CLEAR]) begin
                    nxt_dig_rst = 1'b0;
                end
            end
        end
        // latched drops: a drop in the read cycle stays latched
        nxt_lost_chan = (lost_chan_ff && !(rd_acc &&
            idx_ff == IDX_LINK_STATUS)) || !link_i.channel_ok;
        nxt_lost_descr = (lost_descr_ff && !(rd_acc &&
            idx_ff == IDX_LINK_STATUS)) || !link_i.descr_lock;
        nxt_lost_link = (lost_link_ff && !(rd_acc &&
            idx_ff == IDX_LINK_STATUS)) || !link_i.link_up;
        nxt_int_seen = (int_seen_ff && !(rd_acc &&
            idx_ff == IDX_LINK_STATUS)) || int_act_ff;
        // interrupt output
        nxt_int_act = cfg_ff[CF_FORCE] || (cfg_ff[CF_INT_EN] &&
            (|(ev_st_ff[0] & ev_en_ff[0]) ||
             |(ev_st_ff[1] & ev_en_ff[1])));
        nxt_int_pin = nxt_int_act ^ cfg_ff[CF_POL];
        nxt_clk_stop = cfg_ff[CF_DIS_CLK] && link_i.power_save;
        nxt_isolate = cfg_ff[CF_ISOLATE] && strap_ff[0];
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_ff <= PH_IDLE;
            idx_ff <= '0;
            wr_ff <= 1'b0;
            mapped_ff <= 1'b0;
            hreadyout_ff <= 1'b1;
            hrdata_ff <= '0;
            ext_ctrl_ff <= '0;
            ext_addr_ff <= '0;
            lost_chan_ff <= 1'b0;
            lost_descr_ff <= 1'b0;
            lost_link_ff <= 1'b0;
            int_seen_ff <= 1'b0;
            duplex_ff <= 1'b1;
            cfg_ff <= CFG_RESET;
            sgmii_rst_ff <= 1'b0;
            dig_rst_ff <= 1'b0;
            rst_cnt_ff <= '0;
            strap_ff <= '0;
            strap_done_ff <= 1'b0;
            int_act_ff <= 1'b0;
            int_pin_ff <= 1'b1;
            clk_stop_ff <= 1'b0;
            isolate_ff <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            idx_ff <= nxt_idx;
            wr_ff <= nxt_wr;
            mapped_ff <= nxt_mapped;
            hreadyout_ff <= nxt_hreadyout;
            hrdata_ff <= nxt_hrdata;
            ext_ctrl_ff <= nxt_ext_ctrl;
            ext_addr_ff <= nxt_ext_addr;
            lost_chan_ff <= nxt_lost_chan;
            lost_descr_ff <= nxt_lost_descr;
            lost_link_ff <= nxt_lost_link;
            int_seen_ff <= nxt_int_seen;
            duplex_ff <= nxt_duplex;
            cfg_ff <= nxt_cfg;
            sgmii_rst_ff <= nxt_sgmii_rst;
            dig_rst_ff <= nxt_dig_rst;
            rst_cnt_ff <= nxt_rst_cnt;
            strap_ff <= nxt_strap;
            strap_done_ff <= nxt_strap_done;
            int_act_ff <= nxt_int_act;
            int_pin_ff <= nxt_int_pin;
            clk_stop_ff <= nxt_clk_stop;
            isolate_ff <= nxt_isolate;
        end
    end

    assign hrdata = {16'h0000, hrdata_ff};
    assign hreadyout = hreadyout_ff;
    assign hresp = 1'b0;
    assign int_pin = int_pin_ff;
    assign mac_clk_stop = clk_stop_ff;
    assign isolate = isolate_ff;
    assign power_save_en = cfg_ff[CF_PSAVE];
    assign debug_en = cfg_ff[CF_DEBUG];
    assign chan_debug_en = cfg_ff[CF_CH_DEBUG];
    assign sgmii_reset = sgmii_rst_ff;
    assign core_reset = dig_rst_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_addr_advance: assert property (
        (wr_acc && idx_ff == IDX_EXT_WINDOW && cmd == CMD_INC_RW)
        |=> ext_addr_ff == $past(ext_addr_ff) + 16'h0001)
        else $error("window address did not advance");
    a_addr_hold: assert property (
        (acc && idx_ff == IDX_EXT_WINDOW && cmd == CMD_DATA)
        |=> $stable(ext_addr_ff))
        else $error("window address moved without advance");
    a_read_no_adv: assert property (
        (rd_acc && idx_ff == IDX_EXT_WINDOW && cmd == CMD_INC_W)
        |=> $stable(ext_addr_ff))
        else $error("read advanced write-only address");
    a_chan_latch: assert property (
        !link_i.channel_ok |=> lost_chan_ff)
        else $error("channel-ok drop not latched");
    a_int_seen: assert property (
        int_act_ff |=> int_seen_ff)
        else $error("interrupt assertion not recorded");
    a_int_polarity: assert property (
        1'b1 |=> int_pin_ff == ($past(cfg_ff[CF_POL]) ^ int_act_ff))
        else $error("interrupt pin level wrong for polarity");
    a_force_int: assert property (
        cfg_ff[CF_FORCE] |=> int_act_ff)
        else $error("forced interrupt not asserted");
    a_int_gated: assert property (
        (!cfg_ff[CF_INT_EN] && !cfg_ff[CF_FORCE]) |=> !int_act_ff)
        else $error("interrupt asserted while disabled");
    a_short_reset: assert property (
        ($rose(sgmii_rst_ff) && $past(cfg_ff[CF_RTIME_LO +: 2]) == 2'h0
         && !dig_rst_ff) |-> ##29 sgmii_rst_ff ##1 !sgmii_rst_ff)
        else $error("shortest reset pulse has wrong width");
    a_clk_gate: assert property (
        (cfg_ff[CF_DIS_CLK] && link_i.power_save) |=> clk_stop_ff)
        else $error("mac clock not stopped in power save");
    a_link_event: assert property (
        events_i.link_chg |=> ev_st_ff[0][13 - EV_STAT_LO])
        else $error("link change event not captured");

endmodule

// [verification/pmr_host.sv]
// ahb-lite host model for the register bank
// assumes hready is the slave's hreadyout
`timescale 1ns/1ps
module pmr_host (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // ----
    // one word transfer, held until hready
    // ----
    task automatic xfer(input logic w, input logic [31:0] a,
            input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= a;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (!hready) @(posedge hclk);
        r = hrdata;
    endtask
endmodule

// [verification/pmr_regs_bench.sv]
// self-checking bench for the management register bank
// assumes the host model in pmr_host.sv
`timescale 1ns/1ps
module pmr_regs_bench;
    import pmr_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout;
    logic rd_pend = 1'b0;
    logic hresp, ps_en, dbg_en, cdbg_en;
    logic [31:0] haddr, hwdata, hrdata, a, d0, d1, d2;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] strap_addr;
    logic int_pin, mac_clk_stop, isolate, sgmii_reset, core_reset;
    pmr_link_t link_i;
    pmr_events_t events_i;
    logic [31:0] expq[$];
    int miscompares, samples_checked, cnt;
    int pos[11] = '{15, 14, 13, 11, 10, 15, 14, 11, 10, 9, 8};
    int tcyc[4] = '{30, 40, 50, 60};
    pmr_host pmr_host_i (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));
    // identity values arbitrary
    pmr_regs #(.ID_HIGH(16'h5a5a), .ID_LOW(16'h0f0f), .RST_CYC1(40),
        .RST_CYC2(50), .RST_CYC3(60)) pmr_regs_i (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .link_i(link_i),
        .events_i(events_i), .strap_addr(strap_addr), .int_pin(int_pin),
        .mac_clk_stop(mac_clk_stop), .isolate(isolate),
        .power_save_en(ps_en), .debug_en(dbg_en), .chan_debug_en(cdbg_en),
        .sgmii_reset(sgmii_reset),
        .core_reset(core_reset));
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // ----
    // helpers
    // ----
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [31:0] ad, input logic [31:0] d);
        logic [31:0] r;
        pmr_host_i.xfer(1'b1, ad, d, r);
    endtask
    task automatic rd(input logic [31:0] ad, input logic [31:0] e);
        logic [31:0] r;
        expq.push_back(e);
        pmr_host_i.xfer(1'b0, ad, 32'h0, r);
    endtask
    task automatic pulse(input int b);
        events_i[b] <= 1'b1;
        @(posedge hclk);
        events_i <= '0;
        repeat (2) @(posedge hclk);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ----
    // read data monitor
    // ----
    always @(posedge hclk) begin
        if (rd_pend && hreadyout) begin
            chk(hrdata, expq.pop_front());
            chk(32'(hresp), 32'h0);
        end
        if (hreadyout) rd_pend = hsel && htrans[1] && !hwrite;
    end
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        stop_test();
    end
    // ----
    // tests
    // ----
    initial begin
        hresetn = 1'b0;
        link_i = 6'b111100;
        events_i = '0;
        strap_addr = 5'h11;
        void'($urandom(32'h5ef9));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(32'h44, 32'h000a);
        rd(32'h40, 32'h0605);
        rd(32'h08, 32'h5a5a);
        rd(32'h0c, 32'h0f0f);
        rd(32'h100, 32'h0);
        link_i <= 6'b000100;
        @(posedge hclk);
        link_i <= 6'b111100;
        rd(32'h40, 32'h0004);
        rd(32'h40, 32'h0605);
        $display("reset and status done");
        a = 32'($urandom_range(0, 13));
        d0 = $urandom & 32'hffff;
        d1 = $urandom & 32'hffff;
        d2 = $urandom & 32'hffff;
        wr(32'h34, 32'hffff);
        rd(32'h34, 32'hc01f);
        wr(32'h34, 32'h0003);
        wr(32'h38, a);
        rd(32'h38, a);
        wr(32'h34, 32'h4003);
        wr(32'h38, d0);
        rd(32'h38, d0);
        rd(32'h38, d0);
        wr(32'h34, 32'h8003);
        wr(32'h38, d1);
        wr(32'h38, d2);
        wr(32'h34, 32'h0003);
        rd(32'h38, a + 2);
        wr(32'h38, a);
        wr(32'h34, 32'hc003);
        rd(32'h38, d1);
        rd(32'h38, d1);
        wr(32'h38, d0);
        wr(32'h34, 32'h8003);
        rd(32'h38, d2);
        wr(32'h34, 32'h0003);
        rd(32'h38, a + 2);
        $display("window done");
        for (int i = 0; i < 11; i++) begin
            pulse(10 - i);
            rd(i < 5 ? 32'h48 : 32'h4c, 32'h1 << pos[i]);
        end
        wr(32'h48, 32'h0020);
        pulse(8);
        chk(int_pin, 1'b0);
        rd(32'h40, 32'h0685);
        rd(32'h48, 32'h2020);
        repeat (3) @(posedge hclk);
        chk(int_pin, 1'b1);
        wr(32'h44, 32'h0008);
        pulse(8);
        chk(int_pin, 1'b1);
        wr(32'h44, 32'h000c);
        repeat (3) @(posedge hclk);
        chk(int_pin, 1'b0);
        wr(32'h44, 32'h0006);
        repeat (3) @(posedge hclk);
        chk(int_pin, 1'b1);
        link_i <= 6'b111101;
        wr(32'h44, 32'hc70a);
        repeat (3) @(posedge hclk);
        chk(mac_clk_stop, 1'b1);
        chk(isolate, 1'b1);
        chk(ps_en, 1'b1);
        chk(dbg_en, 1'b1);
        chk(cdbg_en, 1'b1);
        $display("interrupt and config done");
        for (int c = 0; c < 4; c++) begin
            wr(32'h44, 32'h000a | (c << 4));
            wr(32'h44, 32'h080a | (c << 4));
            cnt = 0;
            for (int k = 0; k < 100 && !(cnt > 0 && !sgmii_reset); k++) begin
                if (sgmii_reset) cnt++;
                @(posedge hclk);
            end
            chk(32'(cnt), 32'(tcyc[c]));
        end
        wr(32'h44, 32'h004a);
        wr(32'h7c, 32'h4000);
        repeat (80) @(posedge hclk);
        rd(32'h7c, 32'h4000);
        chk(core_reset, 1'b1);
        wr(32'h44, 32'h000a);
        wr(32'h7c, 32'h4000);
        repeat (80) @(posedge hclk);
        rd(32'h7c, 32'h0);
        chk(core_reset, 1'b0);
        $display("reset timer done");
        stop_test();
    end
endmodule
